// ### hw/multi_timer_shared_control.sv
// Shared run, synchronization and mode control for a five-channel timer.
//
// Contract
// - Counter advances only while its run bit is set.
// - Run bits reset to zero, counters stopped.
// - Unsynchronized channel presets and clears stay private.
// - Synchronized channels preset and clear together.
// - Synchronization bits reset to zero.
// - Phase select bit sets channel 2 phase counting.
// - Direction bit low: flag on overflow or underflow.
// - Direction bit high: flag on overflow only.
// - Each pulse-mode bit selects its channel's PWM mode.
// - Mode bits all reset to zero.
`timescale 1ns/100ps
module multi_timer_shared_control import timer_ctrl_pkg::*; #(
   parameter int CH = NUM_CH,
   parameter int W = CNT_W
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [DATA_W-1:0] bus_rdata,
   input wire logic [CH-1:0] count_tick,
   input wire logic [CH-1:0] clear_req,
   input wire logic [CH-1:0] preset_req,
   input wire logic [CH-1:0][W-1:0] preset_value,
   input wire logic phase_a_pin,
   input wire logic phase_b_pin,
   output logic [CH-1:0][W-1:0] channel_counter,
   output logic [CH-1:0] overflow_event,
   output logic [CH-1:0] underflow_event,
   output logic [CH-1:0] pulse_mode,
   output logic phase_mode,
   output logic irq
);

   // All state of the block outside the channel counters in one register.
   typedef struct packed {
      logic [7:0] run;
      logic [7:0] sync;
      logic [7:0] mode;
      logic [7:0] status;
      logic [7:0] mask;
      logic [7:0] rdata;
      logic pa_meta;
      logic pa_sync;
      logic pa_prev;
      logic pb_meta;
      logic pb_sync;
      logic pb_prev;
   } ctrl_state_t;

   ctrl_state_t state_q;
   ctrl_state_t state_d;

   logic [CH-1:0] run_bits;
   logic [CH-1:0] group_bits;
   logic [CH-1:0] eff_clear;
   logic [CH-1:0] eff_preset;
   logic [CH-1:0] eff_tick;
   logic [CH-1:0] eff_up;
   logic [CH-1:0] ev_ovf;
   logic [CH-1:0] ev_unf;
   logic [CH-1:0] flag_set;
   logic [CH-1:0][W-1:0] eff_value;
   logic [W-1:0] group_value;
   logic group_clear;
   logic group_preset;
   logic phase_on;
   logic flag_direction_select;
   logic quad_step;
   logic quad_up;
   logic hit_run;
   logic hit_sync;
   logic hit_mode;
   logic hit_status;
   logic hit_mask;

   // Register fields seen by the channel logic come straight from flops, so a
   // write is seen by the counters at the edge after the write edge.
   assign run_bits = state_q.run[CH-1:0];
   assign group_bits = state_q.sync[CH-1:0];
   assign phase_on = state_q.mode[PHASE_BIT];
   assign flag_direction_select = state_q.mode[FLAG_DIRECTION_SELECT_BIT];

   // Address decode against the full byte address.
   assign hit_run = (bus_addr == RUN_CTRL_OFS);
   assign hit_sync = (bus_addr == SYNC_CTRL_OFS);
   assign hit_mode = (bus_addr == MODE_CTRL_OFS);
   assign hit_status = (bus_addr == IRQ_STATUS_OFS);
   assign hit_mask = (bus_addr == IRQ_MASK_OFS);

   // Quadrature decode of the synchronized phase pins. The direction comes
   // from comparing the new level of one pin with the old level of the other.
   assign quad_step = (state_q.pa_sync ^ state_q.pa_prev) |
                      (state_q.pb_sync ^ state_q.pb_prev);
   assign quad_up = state_q.pa_prev ^ state_q.pb_sync;

   // Group-wide clear and preset: any member's request reaches every member.
   assign group_clear = |(clear_req & group_bits);
   assign group_preset = |(preset_req & group_bits);

   // When several members ask for a preset at once, the lowest channel's
   // value wins; the others are dropped rather than merged.
   always_comb begin
      group_value = '0;
      for (int i = CH - 1; i >= 0; i--) begin
         if (preset_req[i] && group_bits[i]) begin
            group_value = preset_value[i];
         end
      end
   end

   // Per-channel steering of clear, preset, tick and direction.
   genvar gi;
   generate
      for (gi = 0; gi < CH; gi++) begin : g_chan
         // A channel outside the group only ever sees its own requests.
         assign eff_clear[gi] = clear_req[gi] |
                                (group_bits[gi] & group_clear);
         assign eff_preset[gi] = preset_req[gi] |
                                 (group_bits[gi] & group_preset);
         assign eff_value[gi] = (group_bits[gi] && group_preset) ?
                                group_value : preset_value[gi];

         if (gi == PHASE_CH) begin : g_phase
            // Phase mode replaces the tick input with pin edges.
            assign eff_tick[gi] = phase_on ? quad_step : count_tick[gi];
            assign eff_up[gi] = phase_on ? quad_up : 1'b1;
         end else begin : g_plain
            assign eff_tick[gi] = count_tick[gi];
            assign eff_up[gi] = 1'b1;
         end

         // Channel 2 may flag underflow depending on the direction bit;
         // other channels only count up and flag overflow.
         if (gi == PHASE_CH) begin : g_flag2
            assign flag_set[gi] = ev_ovf[gi] | (~flag_direction_select & ev_unf[gi]);
         end else begin : g_flag
            assign flag_set[gi] = ev_ovf[gi];
         end

         chan_counter #(
            .W(W)
         ) u_cnt (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .run(run_bits[gi]),
            .tick(eff_tick[gi]),
            .count_up(eff_up[gi]),
            .clear(eff_clear[gi]),
            .preset(eff_preset[gi]),
            .preset_value(eff_value[gi]),
            .count(channel_counter[gi]),
            .ovf(ev_ovf[gi]),
            .unf(ev_unf[gi])
         );
      end
   endgenerate

   // Next-state logic: synchronizers, register writes, sticky status and the
   // one-cycle read data.
   always_comb begin
      state_d = state_q;

      // Pins pass two flops before the decoder looks at them.
      state_d.pa_meta = phase_a_pin;
      state_d.pa_sync = state_q.pa_meta;
      state_d.pa_prev = state_q.pa_sync;
      state_d.pb_meta = phase_b_pin;
      state_d.pb_sync = state_q.pb_meta;
      state_d.pb_prev = state_q.pb_sync;

      // Reserved bits are masked off on write so they never hold a one.
      if (bus_wr && hit_run) begin
         state_d.run = bus_wdata & RUN_WMASK;
      end
      if (bus_wr && hit_sync) begin
         state_d.sync = bus_wdata & SYNC_WMASK;
      end
      if (bus_wr && hit_mode) begin
         state_d.mode = bus_wdata & MODE_WMASK;
      end
      if (bus_wr && hit_mask) begin
         state_d.mask = bus_wdata & IRQ_WMASK;
      end

      // Write-one-to-clear, with a new event in the same cycle winning so
      // that no overflow is ever lost to a racing clear.
      if (bus_wr && hit_status) begin
         state_d.status = state_q.status & ~(bus_wdata & IRQ_WMASK);
      end
      state_d.status[CH-1:0] = state_d.status[CH-1:0] | flag_set;

      // Read data stands for exactly one cycle; unmapped reads give zero.
      state_d.rdata = 8'h00;
      if (bus_rd) begin
         if (hit_run) begin
            state_d.rdata = state_q.run | RUN_RFILL;
         end else if (hit_sync) begin
            state_d.rdata = state_q.sync | SYNC_RFILL;
         end else if (hit_mode) begin
            state_d.rdata = state_q.mode | MODE_RFILL;
         end else if (hit_status) begin
            state_d.rdata = state_q.status | IRQ_RFILL;
         end else if (hit_mask) begin
            state_d.rdata = state_q.mask | IRQ_RFILL;
         end
      end
   end

   // State register with synchronous reset to documented initial values.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q.run <= RUN_RST;
         state_q.sync <= SYNC_RST;
         state_q.mode <= MODE_RST;
         state_q.status <= IRQ_STATUS_RST;
         state_q.mask <= IRQ_MASK_RST;
         state_q.rdata <= 8'h00;
         state_q.pa_meta <= 1'b0;
         state_q.pa_sync <= 1'b0;
         state_q.pa_prev <= 1'b0;
         state_q.pb_meta <= 1'b0;
         state_q.pb_sync <= 1'b0;
         state_q.pb_prev <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs: mode bits go to the compare logic, events to the status logic.
   assign bus_rdata = state_q.rdata;
   assign pulse_mode = state_q.mode[PWM_LSB +: CH];
   assign phase_mode = phase_on;
   assign overflow_event = ev_ovf;
   assign underflow_event = ev_unf;

   // Level interrupt while any unmasked sticky flag is set.
   assign irq = |(state_q.status & state_q.mask);

endmodule

// ### hw/timer_ctrl_pkg.sv
// Shared constants for the five-channel timer control block.
package timer_ctrl_pkg;

   // Channel count, counter width and bus widths.
   localparam int NUM_CH = 5;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 28;
   localparam int DATA_W = 8;

   // Channel that supports phase counting and direction-selected flagging.
   localparam int PHASE_CH = 2;

   // Register byte addresses.
   localparam logic [27:0] RUN_CTRL_OFS = 28'h5ffff00;
   localparam logic [27:0] SYNC_CTRL_OFS = 28'h5ffff01;
   localparam logic [27:0] MODE_CTRL_OFS = 28'h5ffff02;
   localparam logic [27:0] IRQ_STATUS_OFS = 28'h5ffff40;
   localparam logic [27:0] IRQ_MASK_OFS = 28'h5ffff41;

   // Field positions inside the mode register.
   localparam int PWM_LSB = 0;
   localparam int FLAG_DIRECTION_SELECT_BIT = 5;
   localparam int PHASE_BIT = 6;

   // Reset values.
   localparam logic [7:0] RUN_RST = 8'h00;
   localparam logic [7:0] SYNC_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;

   // Writable bits of each register; everything else is reserved.
   localparam logic [7:0] RUN_WMASK = 8'h1f;
   localparam logic [7:0] SYNC_WMASK = 8'h1f;
   localparam logic [7:0] MODE_WMASK = 8'h7f;
   localparam logic [7:0] IRQ_WMASK = 8'h1f;

   // Value that reserved bits show on a read.
   localparam logic [7:0] RUN_RFILL = 8'he0;
   localparam logic [7:0] SYNC_RFILL = 8'he0;
   localparam logic [7:0] MODE_RFILL = 8'h80;
   localparam logic [7:0] IRQ_RFILL = 8'h00;

endpackage

// ### hw/chan_counter.sv
// One timer channel counter with clear, preset, run gating and wrap events.
`timescale 1ns/100ps
module chan_counter import timer_ctrl_pkg::*; #(
   parameter int W = CNT_W
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic tick,
   input wire logic count_up,
   input wire logic clear,
   input wire logic preset,
   input wire logic [W-1:0] preset_value,
   output logic [W-1:0] count,
   output logic ovf,
   output logic unf
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic ovf;
      logic unf;
   } cnt_state_t;

   cnt_state_t state_q;
   cnt_state_t state_d;

   // Clear beats preset, and both act even while stopped so software can
   // load a stopped counter before starting it.
   always_comb begin
      state_d = state_q;
      state_d.ovf = 1'b0;
      state_d.unf = 1'b0;
      if (clear) begin
         state_d.cnt = '0;
      end else if (preset) begin
         state_d.cnt = preset_value;
      end else if (run && tick) begin
         if (count_up) begin
            state_d.ovf = (state_q.cnt == {W{1'b1}});
            state_d.cnt = state_q.cnt + W'(1);
         end else begin
            state_d.unf = (state_q.cnt == '0);
            state_d.cnt = state_q.cnt - W'(1);
         end
      end
   end

   // State register.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign count = state_q.cnt;
   assign ovf = state_q.ovf;
   assign unf = state_q.unf;

endmodule

// ### sim/multi_timer_shared_control_properties.sv
// Port assertions for the shared timer control block.
`timescale 1ns/100ps
module multi_timer_shared_control_properties import timer_ctrl_pkg::*; #(
   parameter int CH = NUM_CH,
   parameter int W = CNT_W
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [DATA_W-1:0] bus_rdata,
   input wire logic [CH-1:0] count_tick,
   input wire logic [CH-1:0] clear_req,
   input wire logic [CH-1:0] preset_req,
   input wire logic [CH-1:0][W-1:0] channel_counter,
   input wire logic [CH-1:0] overflow_event,
   input wire logic [CH-1:0] underflow_event,
   input wire logic [CH-1:0] pulse_mode,
   input wire logic phase_mode,
   input wire logic irq
);
   // One clock domain, so every check shares one clock and sleeps in reset.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Quiet read data outside the answer cycle keeps a stale byte from leaking.
   a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
      else $error("read data not zero outside answer");
   a_unmapped_zero: assert property ($past(bus_rd && bus_addr == 28'h5ffff03) |-> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   // The mode outputs come from the register, so they follow one edge later.
   a_pwm_follow: assert property (bus_wr && bus_addr == MODE_CTRL_OFS |=> pulse_mode == $past(bus_wdata[4:0]))
      else $error("pulse mode does not follow write");
   a_phase_follow: assert property (bus_wr && bus_addr == MODE_CTRL_OFS |=> phase_mode == $past(bus_wdata[6]))
      else $error("phase mode does not follow write");
   // Without a tick, clear or preset the counter must not move at all.
   a_hold_idle: assert property (!$past(count_tick[0] || clear_req != '0 || preset_req != '0) |-> $stable(channel_counter[0]))
      else $error("counter 0 moved without a cause");
   a_ovf_wrap: assert property (overflow_event[0] |-> channel_counter[0] == '0 && $past(channel_counter[0]) == '1)
      else $error("overflow without wrap");
   a_unf_wrap: assert property (underflow_event[2] |-> channel_counter[2] == '1 && $past(channel_counter[2]) == '0)
      else $error("underflow without wrap");
   a_reset_clear: assert property ($rose(rst_n) |-> channel_counter == '0 && pulse_mode == '0 && !phase_mode && !irq)
      else $error("outputs not clear after reset");
endmodule

// ### sim/multi_timer_shared_control_test.sv
// Self-checking bench for the shared timer control block.
`timescale 1ns/100ps
module multi_timer_shared_control_test import timer_ctrl_pkg::*;;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [27:0] bus_addr = '0;
   logic [7:0] bus_wdata = '0;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_rdata;
   logic [4:0] count_tick = '0;
   logic [4:0] clear_req = '0;
   logic [4:0] preset_req = '0;
   logic [4:0][15:0] preset_value = '0;
   logic phase_a_pin = 1'b0;
   logic phase_b_pin = 1'b0;
   logic [4:0][15:0] channel_counter;
   logic [4:0] overflow_event, underflow_event, pulse_mode;
   logic phase_mode, irq;
   logic [4:0][15:0] exp_cnt = '0;
   logic [7:0] v;
   logic [4:0] ovf_seen = '0;
   int bad_count = 0;
   int n_tests = 0;
   int n;
   always #5 core_clk = ~core_clk;
   // Overflow pulses last one cycle, so they are gathered here for a later compare.
   always @(posedge core_clk) ovf_seen <= ovf_seen | overflow_event;
   multi_timer_shared_control uut (.core_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
      .bus_rdata, .count_tick, .clear_req, .preset_req, .preset_value, .phase_a_pin,
      .phase_b_pin, .channel_counter, .overflow_event, .underflow_event, .pulse_mode,
      .phase_mode, .irq);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Bus cycles: strobes last one cycle, read data is taken in the cycle after.
   task automatic wr(input logic [27:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [27:0] a, input logic [7:0] e, input string what);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1 chk(bus_rdata, e, what);
   endtask
   task automatic tk(input logic [4:0] m, input int k);
      repeat (k) begin
         @(posedge core_clk);
         count_tick <= m;
      end
      @(posedge core_clk);
      count_tick <= '0;
      @(posedge core_clk);
   endtask
   // A group member's request spreads over the whole group.
   function automatic logic [4:0] hit(input logic [4:0] req, input logic [4:0] grp);
      return ((req & grp) != '0) ? (req | grp) : req;
   endfunction
   task automatic pr(input logic [4:0] req, input logic clr, input int src, input logic [4:0] sy);
      logic [4:0] g;
      @(posedge core_clk);
      clear_req <= clr ? req : 5'h00;
      preset_req <= clr ? 5'h00 : req;
      @(posedge core_clk);
      clear_req <= '0;
      preset_req <= '0;
      @(posedge core_clk);
      g = hit(req, sy);
      for (int i = 0; i < 5; i++) if (g[i]) exp_cnt[i] = clr ? 16'h0000 : preset_value[src];
   endtask
   task automatic cc(input string what);
      #1 for (int i = 0; i < 5; i++) chk(channel_counter[i], exp_cnt[i], what);
   endtask
   task automatic ph(input logic a, input logic b);
      @(posedge core_clk);
      phase_a_pin <= a;
      phase_b_pin <= b;
      repeat (6) @(posedge core_clk);
   endtask
   // The watchdog cuts a hang short well past the expected run length.
   initial begin
      #100000 bad_count++;
      results();
   end
   initial begin
      void'($urandom(6796));
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(RUN_CTRL_OFS, 8'he0, "run reset");
      rd(SYNC_CTRL_OFS, 8'he0, "sync reset");
      rd(MODE_CTRL_OFS, 8'h80, "mode reset");
      tk(5'h1f, 3);
      cc("stopped");
      wr(RUN_CTRL_OFS, 8'hff);
      rd(RUN_CTRL_OFS, 8'hff, "run reserved");
      wr(MODE_CTRL_OFS, 8'hff);
      rd(MODE_CTRL_OFS, 8'hff, "mode reserved");
      wr(28'h5ffff03, 8'hff);
      rd(28'h5ffff03, 8'h00, "unmapped");
      for (int t = 0; t < 8; t++) begin
         v = 8'($urandom);
         n = $urandom_range(1, 5);
         wr(RUN_CTRL_OFS, v);
         wr(MODE_CTRL_OFS, v & 8'h3f);
         rd(RUN_CTRL_OFS, v | 8'he0, "run");
         chk(pulse_mode, v[4:0], "pulse mode");
         chk(phase_mode, 1'b0, "phase mode");
         tk(5'h1f, n);
         for (int i = 0; i < 5; i++) if (v[i]) exp_cnt[i] += 16'(n);
         cc("count");
      end
      for (int i = 0; i < 5; i++) preset_value[i] <= 16'($urandom);
      pr(5'h02, 1'b0, 1, 5'h00);
      cc("private preset");
      wr(SYNC_CTRL_OFS, 8'h0b);
      rd(SYNC_CTRL_OFS, 8'heb, "sync");
      pr(5'h01, 1'b1, 0, 5'h0b);
      cc("group clear");
      pr(5'h10, 1'b0, 4, 5'h0b);
      cc("outsider preset");
      pr(5'h08, 1'b0, 3, 5'h0b);
      cc("group preset");
      // Channel 2 alone, counting down from the pins, flags per direction bit.
      wr(SYNC_CTRL_OFS, 8'h00);
      wr(IRQ_MASK_OFS, 8'h04);
      wr(IRQ_STATUS_OFS, 8'h1f);
      wr(RUN_CTRL_OFS, 8'h04);
      wr(MODE_CTRL_OFS, 8'h60);
      preset_value[2] <= 16'h0002;
      pr(5'h04, 1'b0, 2, 5'h00);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
      ph(1'b0, 1'b0);
      #1 chk(channel_counter[2], 16'hfffe, "phase count");
      rd(IRQ_STATUS_OFS, 8'h00, "status fdir1");
      chk(irq, 1'b0, "irq fdir1");
      wr(MODE_CTRL_OFS, 8'h40);
      preset_value[2] <= 16'h0001;
      pr(5'h04, 1'b0, 2, 5'h00);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
      rd(IRQ_STATUS_OFS, 8'h04, "status fdir0");
      chk(irq, 1'b1, "irq set");
      wr(IRQ_STATUS_OFS, 8'h04);
      rd(IRQ_STATUS_OFS, 8'h00, "status clear");
      #1 chk(irq, 1'b0, "irq clear");
      // Channels 0 and 2 wrap upward; with the direction bit high overflow still flags.
      wr(MODE_CTRL_OFS, 8'h20);
      wr(RUN_CTRL_OFS, 8'h05);
      wr(IRQ_MASK_OFS, 8'h05);
      preset_value[0] <= 16'hffff;
      preset_value[2] <= 16'hffff;
      pr(5'h05, 1'b0, 0, 5'h00);
      tk(5'h05, 1);
      #1 chk(ovf_seen, 16'h0005, "overflow events");
      chk(channel_counter[0], 16'h0000, "wrap ch0");
      chk(channel_counter[2], 16'h0000, "wrap ch2");
      rd(IRQ_STATUS_OFS, 8'h05, "status overflow");
      chk(irq, 1'b1, "irq overflow");
      // A second reset in mid-run must bring the mode and run registers back.
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(MODE_CTRL_OFS, 8'h80, "mode rereset");
      rd(RUN_CTRL_OFS, 8'he0, "run rereset");
      results();
   end
endmodule
bind multi_timer_shared_control multi_timer_shared_control_properties #(.CH(CH), .W(W)) chk_i (
   .core_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .count_tick,
   .clear_req, .preset_req, .channel_counter, .overflow_event, .underflow_event, .pulse_mode,
   .phase_mode, .irq);
